// ---- verilog/plr_ref_policy.sv ----
// APB register bank and automatic reference selection for the primary loop
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "plr_params.svh"
// Summary of operation
// R01 - Failure mask bits 4 to 7 enable single cycle, coarse frequency, guard soak and precise frequency for holdover.
// R02 - A holdover mask bit of zero keeps its indicator from forcing holdover, a one lets it take part.
// R03 - A failed reference must stay fault free for the programmed 0 to 15 whole minutes before it is usable.
// R04 - Revert enable bit n controls reference n, zero non-revertive and one revertive.
// R05 - Priority bits 3:0 rank reference 0 in automatic mode, 0000 highest and 1111 lowest.
// R06 - In automatic mode the best qualified reference is used, a failing one is replaced, and holdover follows if none.
// R07 - Failure mask bits 0 to 3 enable the same four monitors for automatic switching.
// R08 - A revertive higher-priority reference that becomes usable again is taken back, otherwise the current one stays.
module plr_ref_policy
	import plr_pkg::*;
#(
	parameter int unsigned MINUTE_CYCLES = `PLR_MINUTE_SEC * `PLR_CLK_HZ
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] loop_mode,
	input wire plr_monitor_vec_t ref_monitors,
	input wire logic [7:1][3:0] other_ranks,
	output logic [3:0] selected_ref,
	output logic in_holdover,
	output logic [7:0] ref_usable
);
	logic [7:0] primary_loop_failure_masks;
	logic [3:0] primary_loop_requalify_delay;
	logic [7:0] primary_loop_revert_enables;
	logic [7:0] primary_loop_priority_low;
	plr_state_t state;
	plr_state_t next_state;
	logic [2:0] cur;
	logic [2:0] next_cur;
	logic [30:0] prescale;
	logic minute_tick;
	logic [7:0] sw_fault;
	logic [7:0] hold_fault;
	logic [7:0] qual;
	logic [7:0] usable;
	logic [7:0] cur_onehot;
	plr_rank_vec_t ranks;
	plr_pick_t best;
	plr_pick_t alt;
	logic auto_mode;
	logic setup;
	logic wr_en;
	logic mapped;
	logic [7:0] rd_value;

	function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
		return addr == {idx, 2'b00};
	endfunction : hit

	function automatic plr_pick_t pick_best(input logic [7:0] cand, input plr_rank_vec_t rk);
		plr_pick_t p;
		p = '0;
		for (int i = 0; i < `PLR_NUM_REFS; i++)
			if (cand[i] && (!p.valid || rk[i] < rk[p.idx]))
			begin
				p.valid = 1'b1;
				p.idx = 3'(i);
			end
		return p;
	endfunction : pick_best

	assign setup = psel && !penable;
	assign wr_en = ce && psel && penable && pready && pwrite;
	assign mapped = hit(paddr, `PLR_IDX_FAIL_MASK) || hit(paddr, `PLR_IDX_DELAY) || hit(paddr, `PLR_IDX_REVERT)
		|| hit(paddr, `PLR_IDX_PRIO) || hit(paddr, `PLR_IDX_STATUS);

	always_comb
	begin
		rd_value = 8'h00;
		if (hit(paddr, `PLR_IDX_FAIL_MASK))
			rd_value = primary_loop_failure_masks;
		else if (hit(paddr, `PLR_IDX_DELAY))
			rd_value = {4'h0, primary_loop_requalify_delay};
		else if (hit(paddr, `PLR_IDX_REVERT))
			rd_value = primary_loop_revert_enables;
		else if (hit(paddr, `PLR_IDX_PRIO))
			rd_value = primary_loop_priority_low;
		else if (hit(paddr, `PLR_IDX_STATUS))
		begin
			rd_value[`PLR_STAT_HOLD_BIT] = state == PLR_ST_HOLDOVER;
			rd_value[`PLR_STAT_LOCK_BIT] = state == PLR_ST_LOCKED;
			rd_value[2:0] = cur;
		end
	end

	// Answer in the first cycle of the access phase, with no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready <= setup;
			if (setup)
			begin
				pslverr <= !mapped;
				prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			primary_loop_failure_masks <= `PLR_RST_FAIL_MASK;
			primary_loop_requalify_delay <= `PLR_RST_DELAY;
			primary_loop_revert_enables <= `PLR_RST_REVERT;
			primary_loop_priority_low <= `PLR_RST_PRIO;
		end
		else if (wr_en)
		begin
			if (hit(paddr, `PLR_IDX_FAIL_MASK))
				primary_loop_failure_masks <= pwdata[7:0]; // [R01] [R07]
			if (hit(paddr, `PLR_IDX_DELAY))
				primary_loop_requalify_delay <= pwdata[3:0]; // [R03]
			if (hit(paddr, `PLR_IDX_REVERT))
				primary_loop_revert_enables <= pwdata[7:0]; // [R04]
			if (hit(paddr, `PLR_IDX_PRIO))
				primary_loop_priority_low <= pwdata[7:0]; // [R05]
		end
	end

	// One shared minute prescaler instead of eight wide counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale <= 31'h0000_0000;
			minute_tick <= 1'b0;
		end
		else if (ce)
		begin
			minute_tick <= prescale == 31'(MINUTE_CYCLES - 1);
			prescale <= (prescale == 31'(MINUTE_CYCLES - 1)) ? 31'h0000_0000 : prescale + 31'h0000_0001;
		end
	end

	always_comb
	begin
		ranks = {other_ranks, primary_loop_priority_low[3:0]}; // [R05]
		for (int i = 0; i < `PLR_NUM_REFS; i++)
		begin
			sw_fault[i] = |(ref_monitors[i] & primary_loop_failure_masks[`PLR_SW_LSB +: `PLR_FIELD_W]); // [R07]
			hold_fault[i] = |(ref_monitors[i] & primary_loop_failure_masks[`PLR_HOLD_LSB +: `PLR_FIELD_W]); // [R01] [R02]
		end
	end

	genvar g;
	generate
		for (g = 0; g < `PLR_NUM_REFS; g++)
		begin : g_qual
			plr_requalify u_requalify (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.minute_tick(minute_tick),
				.fault(sw_fault[g] | hold_fault[g]),
				.delay_minutes(primary_loop_requalify_delay),
				.qualified(qual[g])
			);
		end
	endgenerate

	assign usable = qual & ~sw_fault & ~hold_fault; // [R03]
	assign cur_onehot = 8'h01 << cur;
	assign best = pick_best(usable, ranks);
	assign alt = pick_best(usable & ~cur_onehot, ranks);
	assign auto_mode = loop_mode == `PLR_MODE_AUTO;

	always_comb
	begin
		next_state = state;
		next_cur = cur;
		case (state)
			PLR_ST_MANUAL:
				if (auto_mode)
				begin
					next_state = best.valid ? PLR_ST_LOCKED : PLR_ST_HOLDOVER; // [R06]
					next_cur = best.valid ? best.idx : cur;
				end
			PLR_ST_LOCKED:
				if (sw_fault[cur] && alt.valid)
					next_cur = alt.idx; // [R06] [R07]
				else if (hold_fault[cur] || sw_fault[cur])
				begin
					// A switch-only fault with no spare still goes to holdover
					if (hold_fault[cur] || !alt.valid)
						next_state = PLR_ST_HOLDOVER; // [R02] [R06]
				end
				else if (alt.valid && ranks[alt.idx] < ranks[cur] && primary_loop_revert_enables[alt.idx])
					next_cur = alt.idx; // [R04] [R08]
			PLR_ST_HOLDOVER:
				if (best.valid)
				begin
					next_state = PLR_ST_LOCKED; // [R06]
					next_cur = best.idx;
				end
			default:
				next_state = PLR_ST_MANUAL;
		endcase
		if (!auto_mode)
			next_state = PLR_ST_MANUAL;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= PLR_ST_MANUAL;
			cur <= 3'h0;
			selected_ref <= 4'h0;
			in_holdover <= 1'b0;
			ref_usable <= 8'h00;
		end
		else if (ce)
		begin
			state <= next_state;
			cur <= next_cur;
			selected_ref <= {1'b0, next_cur};
			in_holdover <= next_state == PLR_ST_HOLDOVER;
			ref_usable <= usable;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_hold_enter;
		(ce && auto_mode && state == PLR_ST_LOCKED && hold_fault[cur] && !(sw_fault[cur] && alt.valid))
			|=> in_holdover && state == PLR_ST_HOLDOVER;
	endproperty
	a_hold_enter: assert property (p_hold_enter) else $error("enabled holdover indicator ignored"); // [R01]

	property p_hold_masked;
		(ce && auto_mode && state == PLR_ST_LOCKED && !hold_fault[cur] && !sw_fault[cur]) |=> !in_holdover;
	endproperty
	a_hold_masked: assert property (p_hold_masked) else $error("holdover without an enabled fault"); // [R02]

	property p_switch;
		(ce && auto_mode && state == PLR_ST_LOCKED && sw_fault[cur] && alt.valid)
			|=> selected_ref == {1'b0, $past(alt.idx)} && state == PLR_ST_LOCKED;
	endproperty
	a_switch: assert property (p_switch) else $error("failed reference not replaced"); // [R07]

	property p_holdover_exit;
		(ce && auto_mode && state == PLR_ST_HOLDOVER && best.valid) |=> !in_holdover && cur == $past(best.idx);
	endproperty
	a_holdover_exit: assert property (p_holdover_exit) else $error("usable reference not taken from holdover"); // [R06]

	property p_revert;
		(ce && auto_mode && state == PLR_ST_LOCKED && !sw_fault[cur] && !hold_fault[cur] && alt.valid
			&& ranks[alt.idx] < ranks[cur] && primary_loop_revert_enables[alt.idx]) |=> cur == $past(alt.idx);
	endproperty
	a_revert: assert property (p_revert) else $error("revertive reference not taken back"); // [R04]

	property p_no_revert;
		(ce && auto_mode && state == PLR_ST_LOCKED && !sw_fault[cur] && !hold_fault[cur]
			&& !(alt.valid && primary_loop_revert_enables[alt.idx])) |=> $stable(cur);
	endproperty
	a_no_revert: assert property (p_no_revert) else $error("non-revertive selection moved"); // [R08]

	property p_prio_write;
		(wr_en && hit(paddr, `PLR_IDX_PRIO)) |=> primary_loop_priority_low == $past(pwdata[7:0]);
	endproperty
	a_prio_write: assert property (p_prio_write) else $error("priority write lost"); // [R05]

	property p_delay_read;
		(ce && setup && !pwrite && hit(paddr, `PLR_IDX_DELAY)) |=> pready && prdata[31:4] == 28'h000_0000;
	endproperty
	a_delay_read: assert property (p_delay_read) else $error("delay read returned reserved bits"); // [R03]

	property p_usable_masked;
		(ce && presetn) |=> ref_usable == ($past(qual) & ~$past(sw_fault) & ~$past(hold_fault));
	endproperty
	a_usable_masked: assert property (p_usable_masked) else $error("usable vector ignores masks"); // [R07]

	c_switch: cover property (ce && state == PLR_ST_LOCKED && sw_fault[cur] && alt.valid);
	c_holdover: cover property (ce && state == PLR_ST_LOCKED ##1 state == PLR_ST_HOLDOVER);
	c_revert: cover property (ce && state == PLR_ST_LOCKED && !sw_fault[cur] && alt.valid
		&& primary_loop_revert_enables[alt.idx] && ranks[alt.idx] < ranks[cur]);
	c_unmapped: cover property (ce && setup && !mapped);
endmodule : plr_ref_policy
`default_nettype wire

// ---- inc/plr_params.svh ----
// Address indices, reset values, field positions and timing for the reference policy registers
`ifndef PLR_PARAMS_SVH
`define PLR_PARAMS_SVH
`define PLR_IDX_FAIL_MASK 6'h21
`define PLR_IDX_DELAY 6'h22
`define PLR_IDX_REVERT 6'h23
`define PLR_IDX_PRIO 6'h24
`define PLR_IDX_STATUS 6'h26
`define PLR_RST_FAIL_MASK 8'h3C
`define PLR_RST_DELAY 4'h0
`define PLR_RST_REVERT 8'h00
`define PLR_RST_PRIO 8'h10
`define PLR_SW_LSB 0
`define PLR_HOLD_LSB 4
`define PLR_FIELD_W 4
`define PLR_MODE_AUTO 3'h3
`define PLR_NUM_REFS 8
`define PLR_MINUTE_SEC 60
`define PLR_CLK_HZ 20000000
`define PLR_MIN_SAT 5'h10
`define PLR_STAT_HOLD_BIT 7
`define PLR_STAT_LOCK_BIT 6
`endif

// ---- inc/plr_pkg.sv ----
// Types shared by the reference policy register block
package plr_pkg;
	typedef enum logic [1:0] {
		PLR_ST_MANUAL = 2'b00,
		PLR_ST_LOCKED = 2'b01,
		PLR_ST_HOLDOVER = 2'b10
	} plr_state_t;
	typedef struct packed {
		logic precise_frequency_monitor;
		logic guard_soak_timer;
		logic coarse_frequency_monitor;
		logic single_cycle_monitor;
	} plr_monitors_t;
	typedef plr_monitors_t [7:0] plr_monitor_vec_t;
	typedef logic [7:0][3:0] plr_rank_vec_t;
	typedef struct packed {
		logic valid;
		logic [2:0] idx;
	} plr_pick_t;
endpackage : plr_pkg

// ---- verilog/plr_requalify.sv ----
// Requalify_delay_minutes qualifier for one reference
`timescale 1ns/1ns
`default_nettype none
`include "plr_params.svh"
module plr_requalify
	import plr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic minute_tick,
	input wire logic fault,
	input wire logic [3:0] delay_minutes,
	output logic qualified
);
	logic [4:0] minutes;
	logic delay_done;

	// Shared tick makes the first minute partial, so one extra tick is required
	assign delay_done = (delay_minutes == 4'h0) || (minutes > {1'b0, delay_minutes});

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			qualified <= 1'b1;
			minutes <= 5'h00;
		end
		else if (ce)
		begin
			if (fault)
			begin
				qualified <= 1'b0; // [R03]
				minutes <= 5'h00;
			end
			else if (!qualified)
			begin
				if (delay_done)
					qualified <= 1'b1; // [R03]
				else if (minute_tick && minutes != `PLR_MIN_SAT)
					minutes <= minutes + 5'h01;
			end
		end
	end

	property p_fault_drops;
		@(posedge pclk) disable iff (!presetn)
		(ce && fault) |=> !qualified;
	endproperty
	a_fault_drops: assert property (p_fault_drops) else $error("qualified stayed high after a fault"); // [R03]

	property p_wait_holds;
		@(posedge pclk) disable iff (!presetn)
		(ce && !qualified && delay_minutes != 4'h0 && minutes <= {1'b0, delay_minutes}) |=> !qualified;
	endproperty
	a_wait_holds: assert property (p_wait_holds) else $error("requalified before the delay ran out"); // [R03]
endmodule : plr_requalify
`default_nettype wire

// ---- testbench/plr_ref_policy_tb.sv ----
// Self-checking testbench for the reference policy register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import plr_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, in_holdover, er;
	logic [7:0] paddr, ad, d, ref_usable;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] loop_mode, r;
	plr_monitor_vec_t ref_monitors;
	logic [7:1][3:0] other_ranks;
	logic [7:0][3:0] rk;
	logic [3:0] selected_ref, s, a;
	int error_cnt, checks_done, cyc, seed, k;
	plr_ref_policy #(.MINUTE_CYCLES(20)) plr_ref_policy_i (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .loop_mode(loop_mode), .ref_monitors(ref_monitors),
		.other_ranks(other_ranks), .selected_ref(selected_ref), .in_holdover(in_holdover),
		.ref_usable(ref_usable));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			summarize();
		end
	end
	// Best usable reference; equal ranks go to the lower index, 4'hF when none
	function automatic logic [3:0] pick(input logic [7:0] ok);
		logic [3:0] b;
		b = 4'hF;
		for (int i = 0; i < 8; i++)
			if (ok[i] && (b == 4'hF || rk[i] < rk[b[2:0]]))
				b = i[3:0];
		return b;
	endfunction : pick
	task summarize;
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task chk(input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] ad_i, input logic [7:0] d_i);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad_i;
		pwdata <= {24'h000000, d_i};
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for pready; if it never rises only the bench timeout ends this wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input logic [7:0] ad_i, input logic [7:0] e, input logic ee);
		apb(1'b0, ad_i, 8'h00);
		chk({3'h0, er, rd}, {3'h0, ee, 24'h000000, e});
	endtask : rdc
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task sel(input logic h, input logic [3:0] e);
		chk({31'h0, in_holdover, selected_ref}, {31'h0, h, e});
	endtask : sel
	initial
	begin
		seed = 27;
		error_cnt = 0;
		checks_done = 0;
		cyc = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		loop_mode = 3'h0;
		ref_monitors = '0;
		other_ranks = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h84, 8'h3C, 1'b0);
		rdc(8'h88, 8'h00, 1'b0);
		rdc(8'h8C, 8'h00, 1'b0);
		rdc(8'h90, 8'h10, 1'b0);
		rdc(8'hA0, 8'h00, 1'b1);
		for (k = 0; k < 8; k++)
		begin
			d = 8'($random(seed));
			ad = 8'h84 + 8'(4 * (k % 4));
			apb(1'b1, ad, d);
			rdc(ad, (k % 4 == 1) ? {4'h0, d[3:0]} : d, 1'b0);
		end
		// Distinct ranks so that a revert always has a strictly better target
		r = 3'($random(seed));
		for (k = 0; k < 8; k++)
			rk[k] = {1'b0, k[2:0] ^ r};
		other_ranks <= rk[7:1];
		apb(1'b1, 8'h90, {4'hA, rk[0]});
		apb(1'b1, 8'h84, 8'hFF);
		apb(1'b1, 8'h88, 8'h00);
		apb(1'b1, 8'h8C, 8'h00);
		loop_mode <= 3'h3;
		wt(4);
		s = pick(8'hFF);
		sel(1'b0, s);
		ref_monitors[s[2:0]].single_cycle_monitor <= 1'b1;
		wt(3);
		a = pick(8'hFF & ~(8'h01 << s[2:0]));
		sel(1'b0, a);
		chk({28'h0, ref_usable}, {28'h0, ~(8'h01 << s[2:0])});
		ref_monitors[s[2:0]].single_cycle_monitor <= 1'b0;
		wt(4);
		sel(1'b0, a);
		apb(1'b1, 8'h84, 8'hBB);
		ref_monitors[a[2:0]].guard_soak_timer <= 1'b1;
		wt(4);
		sel(1'b0, a);
		chk({28'h0, ref_usable}, {28'h0, 8'hFF});
		ref_monitors[a[2:0]].guard_soak_timer <= 1'b0;
		apb(1'b1, 8'h84, 8'hF0);
		ref_monitors[a[2:0]].coarse_frequency_monitor <= 1'b1;
		wt(2);
		chk({35'h0, in_holdover}, 36'h1);
		// Holdover lasts one cycle while another reference is still usable
		wt(2);
		sel(1'b0, s);
		ref_monitors[a[2:0]].coarse_frequency_monitor <= 1'b0;
		loop_mode <= 3'h0;
		wt(2);
		loop_mode <= 3'h3;
		wt(4);
		sel(1'b0, s);
		apb(1'b1, 8'h84, 8'hFF);
		apb(1'b1, 8'h88, 8'h02);
		apb(1'b1, 8'h8C, 8'hFF);
		ref_monitors[s[2:0]].precise_frequency_monitor <= 1'b1;
		wt(3);
		sel(1'b0, a);
		ref_monitors[s[2:0]].precise_frequency_monitor <= 1'b0;
		// Two minutes of 20 cycles must pass before the old reference is usable
		wt(30);
		sel(1'b0, a);
		chk({35'h0, ref_usable[s[2:0]]}, 36'h0);
		wt(40);
		sel(1'b0, s);
		apb(1'b1, 8'h84, 8'h01);
		// Enable low must freeze the selection although every reference fails
		ce <= 1'b0;
		for (k = 0; k < 8; k++)
			ref_monitors[k].single_cycle_monitor <= 1'b1;
		wt(4);
		sel(1'b0, s);
		ce <= 1'b1;
		wt(4);
		chk({35'h0, in_holdover}, 36'h1);
		rdc(8'h98, {2'b10, 3'h0, s[2:0]}, 1'b0);
		summarize();
	end
endmodule : testbench
`default_nettype wire
